// *** fec_flash_operation_error_checker.sv ***
// Flash operation error checker with its APB register slave
//
// Behaviour
// R1 - Flash data write without program modes: sequence
// R2 - Burst start needs full ordered ready buffer
// R3 - Program set while other commands busy: sequence
// R4 - Option-one launch busy or bad codes: sequence
// R5 - Option-zero erase set while busy: sequence
// R6 - Option-zero write set while busy: sequence
// R7 - Main bulk erase set while busy (burst mode excepted): sequence
// R8 - Data bulk erase busy or absent: sequence
// R9 - Sector erase busy or bad address: sequence
// R10 - Blank check crossing 1KB or invalid: sequence
// R11 - EEPROM access while buffer unready: sequence
// R12 - Blank check set while busy: sequence
// R13 - Non 32-bit program write: alignment error
// R14 - Word pair within one double-word, else alignment
// R15 - Program onto non-erased location: not-erased error
// R16 - Program onto protected address: protection error
// R17 - Erase start on protected range: protection error
// R18 - Low read protection plus unsafe boot: protection
// R19 - EEPROM write onto protected address: protection
// R20 - Protection flag with enable drives interrupt
// R21 - Failing operations leave array alone; flags sticky
`timescale 1ns/1ps
module fec_flash_operation_error_checker
  import fec_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Data-side bus
  input  wire fec_data_side_bus_t         data_side_bus,
  output logic                   data_side_bus_err,
  // Array and system status
  input  wire logic              loc_erased,
  input  wire logic              burst_buffer_ready,
  input  wire logic              eeprom_buffer_ready,
  input  wire logic              has_data_array,
  input  wire logic [31:0]       wp_main_n,
  input  wire logic [7:0]        wp_eep_n,
  input  wire fec_ctx_t          ctx,
  // Array operations and error interrupt
  output fec_prog_t              prog,
  output logic                   erase_start,
  output logic                   blank_start,
  output logic                   burst_go,
  output logic                   error_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]  cmd_q,       cmd_d;
  logic        irq_en_q,    irq_en_d;
  logic [3:0]  flag_q,      flag_d;
  logic [31:0] addr_q,      addr_d;
  logic [31:0] cfg_q,       cfg_d;
  logic [31:0] prdata_q,    prdata_d;
  logic [6:0]  bw_cnt_q,    bw_cnt_d;
  logic        bw_ok_q,     bw_ok_d;
  logic        bw_szbad_q,  bw_szbad_d;
  logic [23:0] bw_base_q,   bw_base_d;
  logic        pair_q,      pair_d;
  logic [28:0] pair_dw_q,   pair_dw_d;
  fec_prog_t   prog_q,      prog_d;
  logic        erase_q,     erase_d;
  logic        blank_q,     blank_d;
  logic        burst_q,     burst_d;
  logic        derr_q,      derr_d;

  // ----------------------------------------
  // Decode and checks
  // ----------------------------------------
  logic        acc;
  logic        wr;
  logic        mapped;
  logic        rp_block;
  logic        sect_ok;
  logic        bc_bad;
  logic [10:0] bc_end;
  logic [9:0]  bc_len;
  logic [3:0]  eps;
  logic [3:0]  alc;
  logic [7:0]  extra_bad;
  logic [7:0]  cmd_bad;
  logic        d_main;
  logic        d_eep;

  function automatic logic in_main(input logic [31:0] a);
    in_main = (a[31:MAIN_LOG2] == MAIN_BASE[31:MAIN_LOG2]);
  endfunction : in_main

  function automatic logic in_eep(input logic [31:0] a);
    in_eep = (a[31:EEP_LOG2] == EEP_BASE[31:EEP_LOG2]);
  endfunction : in_eep

  assign acc     = psel & penable & ce;
  assign wr      = acc & pwrite;
  assign mapped  = (paddr == OFF_CTRL) | (paddr == OFF_STAT) |
                   (paddr == OFF_ADDR) | (paddr == OFF_CFG);
  assign pready  = ce;
  assign pslverr = acc & ~mapped;

  // Unsafe boot context under low read protection
  assign rp_block = ctx.rp_low & (ctx.boot_sram | ctx.boot_loader | ctx.debug); // R18

  assign sect_ok = in_main(addr_q);
  assign bc_len  = cfg_q[CFG_LEN_LSB +: 10];
  assign bc_end  = {1'b0, addr_q[9:0]} + {1'b0, bc_len};
  assign bc_bad  = (bc_end > BC_BOUND) | ~sect_ok; // R10
  assign eps     = cfg_q[CFG_EPS_LSB +: 4];
  assign alc     = cfg_q[CFG_ALC_LSB +: 4];
  assign d_main  = data_side_bus.valid & in_main(data_side_bus.addr);
  assign d_eep   = data_side_bus.valid & in_eep(data_side_bus.addr);

  // Conditions beyond the busy check, per command bit
  assign extra_bad = {~sect_ok, 1'b0, ~has_data_array, 2'b00, bc_bad, 2'b00}; // R8 R9

  // Busy check per command, one table entry each
  genvar gi;
  for (gi = 0; gi < CMD_N; gi++)
  begin : g_cmd
    assign cmd_bad[gi] = (|(cmd_q & CONFLICT[gi])) | extra_bad[gi]; // R3 R5 R6 R7 R12
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] new_set;
    logic [7:0] refused;
    logic [3:0] err;
    logic [3:0] clr;
    logic [3:0] derr;
    new_set    = 8'h00;
    refused    = 8'h00;
    err        = 4'h0;
    clr        = 4'h0;
    derr       = 4'h0;
    cmd_d      = cmd_q;
    irq_en_d   = irq_en_q;
    addr_d     = addr_q;
    cfg_d      = cfg_q;
    prdata_d   = prdata_q;
    bw_cnt_d   = bw_cnt_q;
    bw_ok_d    = bw_ok_q;
    bw_szbad_d = bw_szbad_q;
    bw_base_d  = bw_base_q;
    pair_d     = pair_q;
    pair_dw_d  = pair_dw_q;
    prog_d     = '0;
    erase_d    = 1'b0;
    blank_d    = 1'b0;
    burst_d    = 1'b0;

    // Read data is caught in the setup phase so it stands all access
    if (psel & ~penable)
    begin
      case (paddr)
        OFF_CTRL: prdata_d = {21'h0, irq_en_q, 2'b00, cmd_q};
        OFF_STAT: prdata_d = {28'h0, flag_q};
        OFF_ADDR: prdata_d = addr_q;
        OFF_CFG:  prdata_d = cfg_q;
        default:  prdata_d = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          new_set  = pwdata[7:0] & ~cmd_q;
          refused  = new_set & cmd_bad; // R3 R5 R6 R7 R8 R9 R10 R12
          cmd_d    = pwdata[7:0] & ~refused;
          irq_en_d = pwdata[C_IRQEN];
          if (|refused)
            err[F_SEQ] = 1'b1;
          // Fresh burst mode starts tracking from entry 0
          if (new_set[C_BW])
          begin
            bw_cnt_d   = 7'h00;
            bw_ok_d    = 1'b1;
            bw_szbad_d = 1'b0;
          end
          if (new_set[C_PG])
            pair_d = 1'b0;
          if (pwdata[C_O1L])
          begin
            if ((|cmd_q) | ~EPS_VALID[eps] | ~ALC_VALID[alc]) // R4
              err[F_SEQ] = 1'b1;
          end
          if (pwdata[C_START])
          begin
            if (cmd_q[C_BW])
            begin
              // Burst checks happen only at start
              if (~bw_ok_q | (bw_cnt_q != BW_WORDS) | ~burst_buffer_ready) // R2
                err[F_SEQ] = 1'b1;
              if (bw_szbad_q) // R13
                err[F_ALIGN] = 1'b1;
              if (rp_block) // R18
                err[F_PROT] = 1'b1;
              burst_d = ~(|err); // R21
            end
            else if (cmd_q[C_BC])
            begin
              if (rp_block) // R18
                err[F_PROT] = 1'b1;
              blank_d = ~(|err); // R21
            end
            else if (cmd_q[C_MBE] | cmd_q[C_DBE] | cmd_q[C_SE])
            begin
              if (rp_block) // R18
                err[F_PROT] = 1'b1;
              if (cmd_q[C_MBE] & ~(&wp_main_n)) // R17
                err[F_PROT] = 1'b1;
              if (cmd_q[C_SE] & ~wp_main_n[addr_q[MAIN_LOG2-1 -: 5]]) // R17
                err[F_PROT] = 1'b1;
              erase_d = ~(|err); // R21
            end
          end
        end
        OFF_STAT: clr = pwdata[3:0];
        OFF_ADDR: addr_d = pwdata;
        OFF_CFG:  cfg_d = pwdata;
        default:  ;
      endcase
    end

    // Data-side writes into the main array
    if (d_main & data_side_bus.write)
    begin
      if (~cmd_q[C_PG] & ~cmd_q[C_BW]) // R1
        derr[F_SEQ] = 1'b1;
      else if (cmd_q[C_BW])
      begin
        // Entry k must sit at word k of the block that entry 0 opened
        if (data_side_bus.size != SZ_WORD) // R13
          bw_szbad_d = 1'b1;
        if (bw_cnt_q == BW_WORDS)
          bw_ok_d = 1'b0; // R2
        else
        begin
          if (data_side_bus.addr[7:0] != {bw_cnt_q[5:0], 2'b00}) // R2
            bw_ok_d = 1'b0;
          if ((bw_cnt_q != 7'h00) && (data_side_bus.addr[31:8] != bw_base_q)) // R2
            bw_ok_d = 1'b0;
          if (bw_cnt_q == 7'h00)
            bw_base_d = data_side_bus.addr[31:8];
          bw_cnt_d = bw_cnt_q + 7'h01;
        end
      end
      else
      begin
        if (data_side_bus.size != SZ_WORD) // R13
          derr[F_ALIGN] = 1'b1;
        if (~pair_q & (data_side_bus.addr[2:0] != 3'h0)) // R14
          derr[F_ALIGN] = 1'b1;
        if (pair_q & ((data_side_bus.addr[31:3] != pair_dw_q) | (data_side_bus.addr[2:0] != 3'h4))) // R14
          derr[F_ALIGN] = 1'b1;
        if (~loc_erased) // R15
          derr[F_NERAS] = 1'b1;
        if (~wp_main_n[data_side_bus.addr[MAIN_LOG2-1 -: 5]]) // R16
          derr[F_PROT] = 1'b1;
        if (rp_block) // R18
          derr[F_PROT] = 1'b1;
        // A failed word restarts pairing at a double-word boundary
        if (|derr)
          pair_d = 1'b0;
        else
        begin
          pair_d    = ~pair_q;
          pair_dw_d = data_side_bus.addr[31:3];
          prog_d    = '{valid: 1'b1, eep: 1'b0, addr: data_side_bus.addr, data: data_side_bus.wdata}; // R21
        end
      end
    end

    // Data-side accesses to the EEPROM region
    if (d_eep)
    begin
      if (~eeprom_buffer_ready) // R11
        derr[F_SEQ] = 1'b1;
      if (data_side_bus.write & ~wp_eep_n[data_side_bus.addr[EEP_LOG2-1 -: 3]]) // R19
        derr[F_PROT] = 1'b1;
      if (data_side_bus.write & rp_block) // R18
        derr[F_PROT] = 1'b1;
      if (data_side_bus.write & ~(|derr))
        prog_d = '{valid: 1'b1, eep: 1'b1, addr: data_side_bus.addr, data: data_side_bus.wdata}; // R21
    end

    // Hardware set wins over a software clear in the same cycle
    err    = err | derr;
    flag_d = (flag_q & ~clr) | err; // R21
    derr_d = |derr;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q      <= CTRL_RST[7:0];
      irq_en_q   <= CTRL_RST[C_IRQEN];
      flag_q     <= STAT_RST;
      addr_q     <= ADDR_RST;
      cfg_q      <= CFG_RST;
      prdata_q   <= 32'h0000_0000;
      bw_cnt_q   <= 7'h00;
      bw_ok_q    <= 1'b0;
      bw_szbad_q <= 1'b0;
      bw_base_q  <= 24'h00_0000;
      pair_q     <= 1'b0;
      pair_dw_q  <= 29'h0000_0000;
      prog_q     <= '0;
      erase_q    <= 1'b0;
      blank_q    <= 1'b0;
      burst_q    <= 1'b0;
      derr_q     <= 1'b0;
    end
    else if (ce)
    begin
      cmd_q      <= cmd_d;
      irq_en_q   <= irq_en_d;
      flag_q     <= flag_d;
      addr_q     <= addr_d;
      cfg_q      <= cfg_d;
      prdata_q   <= prdata_d;
      bw_cnt_q   <= bw_cnt_d;
      bw_ok_q    <= bw_ok_d;
      bw_szbad_q <= bw_szbad_d;
      bw_base_q  <= bw_base_d;
      pair_q     <= pair_d;
      pair_dw_q  <= pair_dw_d;
      prog_q     <= prog_d;
      erase_q    <= erase_d;
      blank_q    <= blank_d;
      burst_q    <= burst_d;
      derr_q     <= derr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata      = prdata_q;
  assign data_side_bus_err    = derr_q;
  assign prog        = prog_q;
  assign erase_start = erase_q;
  assign blank_start = blank_q;
  assign burst_go    = burst_q;
  assign error_irq   = flag_q[F_PROT] & irq_en_q; // R20

endmodule : fec_flash_operation_error_checker

// *** fec_pkg.sv ***
// Shared constants and types of the flash operation error checker
package fec_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W   = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_ADDR = 12'h008;
  localparam logic [11:0] OFF_CFG  = 12'h00c;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CMD_N   = 8;
  localparam int C_PG    = 0;
  localparam int C_BW    = 1;
  localparam int C_BC    = 2;
  localparam int C_O0E   = 3;
  localparam int C_O0W   = 4;
  localparam int C_DBE   = 5;
  localparam int C_MBE   = 6;
  localparam int C_SE    = 7;
  localparam int C_START = 8;
  localparam int C_O1L   = 9;
  localparam int C_IRQEN = 10;

  // Commands that must be clear before command i may be set
  localparam logic [7:0] CONFLICT [CMD_N] = '{
    8'hfe, 8'h00, 8'hfb, 8'hf7, 8'hef, 8'hdf, 8'hbd, 8'h7f
  };

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int F_SEQ   = 0;
  localparam int F_ALIGN = 1;
  localparam int F_NERAS = 2;
  localparam int F_PROT  = 3;

  // ----------------------------------------
  // Configuration register fields
  // ----------------------------------------
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_EPS_LSB = 16;
  localparam int CFG_ALC_LSB = 20;
  localparam logic [15:0] EPS_VALID = 16'h01ff;
  localparam logic [15:0] ALC_VALID = 16'h003f;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [3:0]  STAT_RST = 4'h0;

  // ----------------------------------------
  // Address map and geometry
  // ----------------------------------------
  localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
  localparam int          MAIN_LOG2 = 19;
  localparam logic [31:0] EEP_BASE  = 32'h0900_0000;
  localparam int          EEP_LOG2  = 12;
  localparam logic [6:0]  BW_WORDS  = 7'h40;
  localparam logic [10:0] BC_BOUND  = 11'h400;
  localparam logic [1:0]  SZ_WORD   = 2'h2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fec_data_side_bus_t;

  typedef struct packed {
    logic        valid;
    logic        eep;
    logic [31:0] addr;
    logic [31:0] data;
  } fec_prog_t;

  typedef struct packed {
    logic rp_low;
    logic boot_sram;
    logic boot_loader;
    logic debug;
  } fec_ctx_t;

endpackage : fec_pkg

// *** fec_array_model.sv ***
// Flash cell model that reports the erased state of the addressed word
`timescale 1ns/1ps
module fec_array_model
  import fec_pkg::*;
(
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Accesses and accepted writes
  input  wire fec_data_side_bus_t data_side_bus,
  input  wire fec_prog_t prog,
  // Cell state
  output logic           loc_erased
);
  // ----
  // Programmed word map
  // ----
  // Only 256 words are tracked, so higher offsets alias; tests keep addresses apart
  logic [255:0] used_q;
  logic [255:0] used_d;

  always_comb
  begin
    used_d = used_q;
    if (prog.valid && !prog.eep)
      used_d[prog.addr[9:2]] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      used_q <= '0;
    else
      used_q <= used_d;

  assign loc_erased = !(used_q[data_side_bus.addr[9:2]] && data_side_bus.addr[31:19] == MAIN_BASE[31:19]);
endmodule : fec_array_model

// *** fec_flash_operation_error_checker_assertions.sv ***
// Port checks of the flash operation error checker
`timescale 1ns/1ps
module fec_checker_sva
  import fec_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  // Data side and status
  input wire fec_data_side_bus_t         data_side_bus,
  input wire logic              data_side_bus_err,
  input wire logic              eeprom_buffer_ready,
  input wire logic [31:0]       wp_main_n,
  input wire logic [7:0]        wp_eep_n,
  input wire fec_ctx_t          ctx,
  input wire logic              loc_erased,
  // Array operations
  input wire fec_prog_t         prog,
  input wire logic              erase_start,
  input wire logic              blank_start,
  input wire logic              burst_go
);
  // ----
  // Checks
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Program-mode checks must stay quiet while burst mode collects its block
  logic bw_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bw_q <= 1'b0;
    else if (psel && penable && pwrite && ce && paddr == OFF_CTRL)
      bw_q <= pwdata[C_BW];

  wire mw = data_side_bus.valid && data_side_bus.write && ce && !bw_q && data_side_bus.addr[31:19] == MAIN_BASE[31:19];
  wire ew = data_side_bus.valid && ce && data_side_bus.addr[31:12] == EEP_BASE[31:12];
  wire rp = ctx.rp_low && (ctx.boot_sram || ctx.boot_loader || ctx.debug);
  wire sw = psel && penable && pwrite && ce && paddr == OFF_CTRL && pwdata[C_START];

  AST_EXCL: assert property (!(prog.valid && data_side_bus_err))
    else $error("write accepted and refused at once");
  AST_ECHO: assert property (prog.valid |-> $past(data_side_bus.valid) && prog.data == $past(data_side_bus.wdata))
    else $error("array write without matching bus write");
  AST_UNERASED: assert property (mw && !loc_erased |=> data_side_bus_err && !prog.valid)
    else $error("write onto used cell accepted");
  AST_SIZE: assert property (mw && data_side_bus.size != SZ_WORD |=> data_side_bus_err && !prog.valid)
    else $error("narrow write accepted");
  AST_ALIGN: assert property (mw && data_side_bus.addr[1:0] != 2'h0 |=> data_side_bus_err)
    else $error("unaligned write not refused");
  AST_WP_MAIN: assert property (mw && !wp_main_n[data_side_bus.addr[18:14]] |=> data_side_bus_err && !prog.valid)
    else $error("protected main write accepted");
  AST_RDPROT: assert property (mw && rp |=> data_side_bus_err && !prog.valid)
    else $error("write accepted in locked context");
  AST_EEP_WP: assert property (ew && data_side_bus.write && !wp_eep_n[data_side_bus.addr[11:9]] |=> data_side_bus_err)
    else $error("protected eeprom write not refused");
  AST_EEP_RDY: assert property (ew && !eeprom_buffer_ready |=> data_side_bus_err)
    else $error("eeprom access while unready not refused");
  AST_START: assert property (erase_start || blank_start || burst_go |-> $past(sw) || $past(sw, 2))
    else $error("operation started without start request");
endmodule : fec_checker_sva

bind fec_flash_operation_error_checker fec_checker_sva chk_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .data_side_bus(data_side_bus), .data_side_bus_err(data_side_bus_err),
  .eeprom_buffer_ready(eeprom_buffer_ready), .wp_main_n(wp_main_n), .wp_eep_n(wp_eep_n),
  .ctx(ctx), .loc_erased(loc_erased), .prog(prog), .erase_start(erase_start),
  .blank_start(blank_start), .burst_go(burst_go)
);

// *** fec_flash_operation_error_checker_test.sv ***
// Directed bench for the flash operation error checker
`timescale 1ns/1ps
module fec_flash_operation_error_checker_test
  import fec_pkg::*;
  ;
  // ----
  // Signals and instances
  // ----
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pslv, pv, pe, ce;
  logic        data_side_bus_err, loc_erased, bb_rdy, eep_rdy, has_da, es, bs, bg, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, wp_main_n, pd;
  logic [7:0]  wp_eep_n;
  fec_data_side_bus_t   data_side_bus;
  fec_prog_t   prog;
  fec_ctx_t    ctx;
  int          bad_count, checked, n_erase, n_blank, n_burst;

  fec_flash_operation_error_checker dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_side_bus(data_side_bus), .data_side_bus_err(data_side_bus_err),
    .loc_erased(loc_erased), .burst_buffer_ready(bb_rdy), .eeprom_buffer_ready(eep_rdy),
    .has_data_array(has_da), .wp_main_n(wp_main_n), .wp_eep_n(wp_eep_n), .ctx(ctx),
    .prog(prog), .erase_start(es), .blank_start(bs), .burst_go(bg), .error_irq(irq)
  );
  fec_array_model arr_u (
    .pclk(pclk), .presetn(presetn), .data_side_bus(data_side_bus), .prog(prog), .loc_erased(loc_erased)
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (es === 1'b1)
      n_erase <= n_erase + 1;

  always @(posedge pclk)
    if (bs === 1'b1)
      n_blank <= n_blank + 1;

  always @(posedge pclk)
    if (bg === 1'b1)
      n_burst <= n_burst + 1;

  // ----
  // Tasks
  // ----
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // APB transfer; pready is sampled at each edge of the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      complete_run();
    end
    rdat = prdata;
    pslv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rdat);
  endtask : rd

  task automatic stat(input logic [31:0] e);
    rd(OFF_STAT, e);
    wr(OFF_STAT, 32'hf);
  endtask : stat

  // One data-side access; the accept pulse is sampled one cycle later
  task automatic dw(input logic w, input logic [31:0] a, input logic [1:0] s);
    @(posedge pclk);
    data_side_bus <= '{1'b1, w, s, a, ~a};
    @(posedge pclk);
    data_side_bus.valid <= 1'b0;
    @(posedge pclk);
    pv = prog.valid;
    pe = data_side_bus_err;
    pd = prog.data;
  endtask : dw

  // ----
  // Sequence
  // ----
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    data_side_bus = '0;
    bb_rdy = 1'b0;
    eep_rdy = 1'b1;
    has_da = 1'b1;
    wp_main_n = '1;
    wp_eep_n = '1;
    ctx = '0;
    ce = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_STAT, 32'(STAT_RST));
    rd(OFF_ADDR, ADDR_RST);
    rd(OFF_CFG, CFG_RST);
    rd(12'h010, 32'h0);
    chk(32'h1, 32'(pslv));
    $display("test reset done");
    wr(OFF_CTRL, 32'h1);
    dw(1'b1, 32'h0800_0000, SZ_WORD);
    chk(32'h1, 32'(pv));
    chk(32'hf7ff_ffff, pd);
    dw(1'b1, 32'h0800_0004, SZ_WORD);
    chk(32'h1, 32'(pv));
    dw(1'b1, 32'h0800_0014, SZ_WORD);
    stat(32'h2);
    dw(1'b1, 32'h0800_0021, 2'h0);
    stat(32'h2);
    dw(1'b1, 32'h0800_0000, SZ_WORD);
    chk(32'h0, 32'(pv));
    stat(32'h4);
    wp_main_n <= ~32'h2;
    dw(1'b1, 32'h0800_4100, SZ_WORD);
    wr(OFF_CTRL, 32'h401);
    repeat (2) @(posedge pclk);
    chk(32'h1, 32'(irq));
    stat(32'h8);
    repeat (2) @(posedge pclk);
    chk(32'h0, 32'(irq));
    wp_main_n <= '1;
    ctx <= '{1'b1, 1'b0, 1'b0, 1'b1};
    dw(1'b1, 32'h0800_0200, SZ_WORD);
    stat(32'h8);
    ctx <= '0;
    wp_eep_n <= 8'hfe;
    dw(1'b1, 32'h0900_0000, SZ_WORD);
    stat(32'h8);
    wp_eep_n <= '1;
    $display("test program done");
    wr(OFF_CTRL, 32'h0);
    ce <= 1'b0;
    dw(1'b1, 32'h0800_0300, SZ_WORD);
    chk(32'h0, 32'(pready));
    ce <= 1'b1;
    stat(32'h0);
    dw(1'b1, 32'h0800_0300, SZ_WORD);
    chk(32'h1, 32'(pe));
    stat(32'h1);
    eep_rdy <= 1'b0;
    dw(1'b0, 32'h0900_0000, SZ_WORD);
    stat(32'h1);
    eep_rdy <= 1'b1;
    wr(OFF_ADDR, 32'h0800_4100);
    wr(OFF_CTRL, 32'h80);
    wr(OFF_CTRL, 32'h81);
    rd(OFF_CTRL, 32'h80);
    stat(32'h1);
    wp_main_n <= ~32'h2;
    wr(OFF_CTRL, 32'h180);
    stat(32'h8);
    wp_main_n <= '1;
    wr(OFF_CTRL, 32'h180);
    repeat (2) @(posedge pclk);
    chk(32'h1, 32'(n_erase));
    wr(OFF_CTRL, 32'h0);
    wr(OFF_ADDR, 32'h0800_03f0);
    wr(OFF_CFG, 32'h20);
    wr(OFF_CTRL, 32'h4);
    stat(32'h1);
    wr(OFF_CFG, 32'h00f0_0000);
    wr(OFF_CTRL, 32'h200);
    stat(32'h1);
    has_da <= 1'b0;
    wr(OFF_CTRL, 32'h20);
    stat(32'h1);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_CTRL, 32'h102);
    stat(32'h1);
    bb_rdy <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h2);
      for (int k = 0; k < 64; k++)
        dw(1'b1, 32'h0800_1000 + 32'(4 * k), (p == 0 && k == 3) ? 2'h1 : SZ_WORD);
      wr(OFF_CTRL, 32'h102);
      stat((p == 0) ? 32'h2 : 32'h0);
    end
    chk(32'h1, 32'(n_burst));
    wr(OFF_CTRL, 32'h0);
    wr(OFF_ADDR, 32'h0800_0400);
    wr(OFF_CFG, 32'h20);
    wr(OFF_CTRL, 32'h4);
    ctx <= '{1'b1, 1'b1, 1'b0, 1'b0};
    wr(OFF_CTRL, 32'h104);
    stat(32'h8);
    ctx <= '0;
    wr(OFF_CTRL, 32'h104);
    stat(32'h0);
    chk(32'h1, 32'(n_blank));
    wr(OFF_CTRL, 32'h0c);
    wr(OFF_CTRL, 32'h14);
    wr(OFF_CTRL, 32'h44);
    rd(OFF_CTRL, 32'h4);
    stat(32'h1);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_ADDR, 32'h0);
    wr(OFF_CTRL, 32'h80);
    stat(32'h1);
    $display("test commands done");
    complete_run();
  end
endmodule : fec_flash_operation_error_checker_test
